// ==== hdl/pwd_consts.vh ====
// pwd_consts.vh: constants of the programmable watchdog
// assumes a 250 MHz core clock; included by its bare name
`ifndef PWD_CONSTS_VH
`define PWD_CONSTS_VH

// ----------------------------------------------------------------
// register addresses and reset values
// ----------------------------------------------------------------
`define PWD_ADDR_PARAM 7'h0a
`define PWD_ADDR_CTRL 7'h0c
`define PWD_PARAM_RST 8'hca
`define PWD_CTRL_RST 8'h00
`define PWD_RST_TICKS 10'h3e8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PWD_BIT_EN 7
`define PWD_BIT_RFSH 7
`define PWD_BIT_X1S 6
`define PWD_BIT_X100MS 5
`define PWD_BIT_X10MS 4

// ----------------------------------------------------------------
// multipliers in base ticks of 10 ms, and bcd limits
// ----------------------------------------------------------------
`define PWD_TICKS_1S 10'h064
`define PWD_TICKS_100MS 10'h00a
`define PWD_TICKS_10MS 10'h001
`define PWD_BCD_MAX 4'ha
`define PWD_STEPS 17'h0007f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PWD_CLK_MHZ 250
`define PWD_TICK_MS 10
`define PWD_TICK_CYC (`PWD_TICK_MS * 1000 * `PWD_CLK_MHZ)
`define PWD_PULSE_US 10
`define PWD_PULSE_CYC (`PWD_PULSE_US * `PWD_CLK_MHZ)
`define PWD_FRAME_BITS 5'h10
`define PWD_ADDR_BITS 5'h08

`endif

// ==== hdl/pwd_watchdog.v ====
// pwd_watchdog.v: programmable watchdog with a 16-bit spi register port
// assumes spi mode 0 from the host, a 250 MHz clk_i and an external
// pull-up on the open-drain mcu reset line
`timescale 1ns/1ps
`include "pwd_consts.vh"
`default_nettype none

module pwd_watchdog #(
  parameter integer TICK_CYC = `PWD_TICK_CYC,
  parameter integer PULSE_CYC = `PWD_PULSE_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire spi_sclk_i,
  input wire spi_cs_n_i,
  input wire spi_mosi_i,
  output reg spi_miso_o,
  output reg spi_miso_oe_o,
  output reg mcu_reset_out_n_o,
  output reg mcu_reset_out_n_oe_o
);

  // default config as a sized constant, so its fields can be sliced
  localparam [7:0] PARAM_RST = `PWD_PARAM_RST;

  // ----------------------------------------------------------------
  // interval decode, shared by config and temporary loads
  // ----------------------------------------------------------------
  function [9:0] pwd_ticks;
    input [6:0] f;
    reg [9:0] mul;
    reg [3:0] v;
    begin
      // largest set multiplier wins; none set falls back to 1 s
      if (f[`PWD_BIT_X1S]) mul = `PWD_TICKS_1S;
      else if (f[`PWD_BIT_X100MS]) mul = `PWD_TICKS_100MS;
      else if (f[`PWD_BIT_X10MS]) mul = `PWD_TICKS_10MS;
      else mul = `PWD_TICKS_1S;
      // clamp bcd value into 1..10
      if (f[3:0] == 4'h0) v = 4'h1;
      else if (f[3:0] > `PWD_BCD_MAX) v = `PWD_BCD_MAX;
      else v = f[3:0];
      pwd_ticks = mul * {6'h00, v};
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, stage 2 and 3 must agree
  // ----------------------------------------------------------------
  reg [2:0] sclk_sync_reg, cs_sync_reg, mosi_sync_reg;
  reg sclk_reg, cs_n_reg, mosi_reg;
  reg sclk_old_reg, cs_old_reg;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      mosi_sync_reg <= 3'h0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
      sclk_old_reg <= 1'b0;
      cs_old_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
      cs_sync_reg <= {cs_sync_reg[1:0], spi_cs_n_i};
      mosi_sync_reg <= {mosi_sync_reg[1:0], spi_mosi_i};
      // a glitch shorter than one stage never reaches the filtered level
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) sclk_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2]) cs_n_reg <= cs_sync_reg[2];
      if (mosi_sync_reg[1] == mosi_sync_reg[2]) mosi_reg <= mosi_sync_reg[2];
      sclk_old_reg <= sclk_reg;
      cs_old_reg <= cs_n_reg;
    end
  end

  wire sclk_rise = sclk_reg & ~sclk_old_reg & ~cs_n_reg;
  wire sclk_fall = ~sclk_reg & sclk_old_reg & ~cs_n_reg;
  wire cs_start = ~cs_n_reg & cs_old_reg;
  wire cs_end = cs_n_reg & ~cs_old_reg;

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  reg [15:0] shift_reg;
  reg [4:0] bit_cnt_reg;
  reg [7:0] rd_shift_reg;
  reg [7:0] param_reg;
  reg [7:0] ctrl_reg;
  reg [9:0] rem_reg;
  reg [9:0] total_reg;
  reg [31:0] presc_reg;
  reg [31:0] pulse_reg;
  reg pulse_on_reg;

  wire [7:0] frame_hdr = {shift_reg[6:0], mosi_reg};
  wire wr_frame = cs_end && bit_cnt_reg == `PWD_FRAME_BITS
    && shift_reg[15];
  wire wr_param = wr_frame && shift_reg[14:8] == `PWD_ADDR_PARAM;
  wire wr_ctrl = wr_frame && shift_reg[14:8] == `PWD_ADDR_CTRL;
  wire rfsh_wr = wr_ctrl && shift_reg[`PWD_BIT_RFSH]; // refresh_strobe
  wire enabled = param_reg[`PWD_BIT_EN];
  wire tick = presc_reg == TICK_CYC - 1;
  wire timeout = enabled && !pulse_on_reg && tick && rem_reg <= 10'h001;
  wire pulse_done = pulse_on_reg && pulse_reg == PULSE_CYC - 1;

  // timer as fraction of the loaded interval, in 127 steps
  wire [16:0] frac_num = {7'h00, rem_reg} * `PWD_STEPS;
  wire [16:0] frac = frac_num / {7'h00, total_reg};
  wire [7:0] status = {enabled, frac[6:0]};

  // ----------------------------------------------------------------
  // spi frame: write flag, 7-bit address, 8-bit data, msb first
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      rd_shift_reg <= 8'h00;
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      spi_miso_oe_o <= ~cs_n_reg;
      // a cut frame must not leave a stale bit on the idle line
      if (cs_n_reg) begin
        spi_miso_o <= 1'b0;
      end else if (cs_start) begin
        bit_cnt_reg <= 5'h00;
        spi_miso_o <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[14:0], mosi_reg};
        if (bit_cnt_reg != 5'h1f) bit_cnt_reg <= bit_cnt_reg + 5'h01;
        // read data is chosen once the address byte is in
        if (bit_cnt_reg == `PWD_ADDR_BITS - 5'h01) begin
          if (frame_hdr[6:0] == `PWD_ADDR_PARAM) rd_shift_reg <= status;
          else if (frame_hdr[6:0] == `PWD_ADDR_CTRL)
            rd_shift_reg <= ctrl_reg;
          else rd_shift_reg <= 8'h00;
        end
      end else if (sclk_fall && bit_cnt_reg >= `PWD_ADDR_BITS) begin
        spi_miso_o <= rd_shift_reg[7];
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and control registers
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      param_reg <= `PWD_PARAM_RST;
      ctrl_reg <= `PWD_CTRL_RST;
    end else if (pulse_on_reg) begin
      // any reset pulse restores 10 s, enabled
      param_reg <= `PWD_PARAM_RST;
      ctrl_reg <= `PWD_CTRL_RST;
    end else begin
      if (wr_param) param_reg <= shift_reg[7:0];
      // a refresh loads the counter, which clears control
      if (rfsh_wr) ctrl_reg <= `PWD_CTRL_RST;
      else if (wr_ctrl) ctrl_reg <= shift_reg[7:0];
      else if (timeout) ctrl_reg <= `PWD_CTRL_RST;
    end
  end

  // ----------------------------------------------------------------
  // interval counter, 10 ms prescaler and reset pulse
  // ----------------------------------------------------------------
  reg [6:0] load_sel;
  always @* begin
    // temporary value wins only if bits 6..0 are non-zero
    if (rfsh_wr && shift_reg[6:0] != 7'h00) load_sel = shift_reg[6:0];
    else if (rfsh_wr) load_sel = param_reg[6:0];
    else if (ctrl_reg[6:0] != 7'h00) load_sel = ctrl_reg[6:0];
    else load_sel = param_reg[6:0];
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rem_reg <= `PWD_RST_TICKS;
      total_reg <= `PWD_RST_TICKS;
      presc_reg <= 32'h0;
      pulse_reg <= 32'h0;
      pulse_on_reg <= 1'b0;
      mcu_reset_out_n_o <= 1'b1;
      mcu_reset_out_n_oe_o <= 1'b0;
    end else begin
      if (pulse_on_reg) begin
        pulse_reg <= pulse_done ? 32'h0 : pulse_reg + 32'h1;
        if (pulse_done) begin
          pulse_on_reg <= 1'b0;
          mcu_reset_out_n_o <= 1'b1;
          mcu_reset_out_n_oe_o <= 1'b0;
          // restart from the default interval after the pulse
          rem_reg <= pwd_ticks(PARAM_RST[6:0]);
          total_reg <= pwd_ticks(PARAM_RST[6:0]);
          presc_reg <= 32'h0;
        end
      end else if (rfsh_wr) begin
        rem_reg <= pwd_ticks(load_sel);
        total_reg <= pwd_ticks(load_sel);
        presc_reg <= 32'h0;
      end else if (!enabled) begin
        presc_reg <= 32'h0; // disabled: no timing, no timeout
      end else if (timeout) begin
        pulse_on_reg <= 1'b1;
        mcu_reset_out_n_o <= 1'b0;
        mcu_reset_out_n_oe_o <= 1'b1;
        rem_reg <= 10'h000;
        presc_reg <= 32'h0;
      end else begin
        presc_reg <= tick ? 32'h0 : presc_reg + 32'h1;
        if (tick) rem_reg <= rem_reg - 10'h001;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb/pwd_watchdog_props.sv ====
// pwd_watchdog_props.sv: port assertions of the watchdog
// assumes PULSE_CYC of 8 and sclk phases of ten clocks
`timescale 1ns/1ps
`default_nettype none
module pwd_watchdog_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic mcu_reset_out_n_o,
  input wire logic mcu_reset_out_n_oe_o
);
  // ----------------------------------------
  // properties, all on clk_i
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hi8; mcu_reset_out_n_oe_o [*8]; endsequence
  property p_plen;
    $rose(mcu_reset_out_n_oe_o) |-> s_hi8 ##1 !mcu_reset_out_n_oe_o;
  endproperty
  a_plen: assert property (p_plen) else $error("pulse len");
  property p_plow; mcu_reset_out_n_oe_o |-> !mcu_reset_out_n_o; endproperty
  a_plow: assert property (p_plow) else $error("pulse lvl");
  property p_gap; $fell(mcu_reset_out_n_oe_o) |-> !mcu_reset_out_n_oe_o [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("pulse gap");
  property p_por; $fell(rst_i) |-> !mcu_reset_out_n_oe_o; endproperty
  a_por: assert property (p_por) else $error("por pulse");
  property p_sidle; !spi_miso_oe_o |-> !spi_miso_o; endproperty
  a_sidle: assert property (p_sidle) else $error("miso idle");
  property p_son; $fell(spi_cs_n_i) |-> ##[2:8] spi_miso_oe_o; endproperty
  a_son: assert property (p_son) else $error("miso oe on");
  property p_soff; spi_cs_n_i [*8] |-> !spi_miso_oe_o; endproperty
  a_soff: assert property (p_soff) else $error("miso oe off");
  property p_hold; spi_sclk_i && $past(spi_sclk_i) |-> $stable(spi_miso_o);
  endproperty
  a_hold: assert property (p_hold) else $error("miso hold");
endmodule
bind pwd_watchdog pwd_watchdog_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_miso_o(spi_miso_o),
  .spi_miso_oe_o(spi_miso_oe_o), .mcu_reset_out_n_o(mcu_reset_out_n_o),
  .mcu_reset_out_n_oe_o(mcu_reset_out_n_oe_o));
`default_nettype wire

// ==== tb/pwd_host_model.sv ====
// pwd_host_model.sv: spi host standing in for the supervised mcu
// assumes mode 0 and ten core clocks per sclk phase
`timescale 1ns/1ps
`default_nettype none
module pwd_host_model (
  input wire logic clk_i,
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic mosi_o,
  input wire logic miso_i
);
  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // one frame; refresh and setup writes both come through here
  task xfer(input logic [15:0] f, output logic [7:0] rd);
    integer i;
    begin
      rd = 8'h00;
      cs_n_o <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        mosi_o <= f[i];
        repeat (10) @(posedge clk_i);
        sclk_o <= 1'b1;
        if (i < 8) rd[i] = miso_i;
        repeat (10) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
      repeat (10) @(posedge clk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~f[0]; // released line must not look valid
      repeat (10) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/pwd_watchdog_bench.sv ====
// pwd_watchdog_bench.sv: self-checking bench of the watchdog
// assumes the host model and a pull-up on the mcu reset line
`timescale 1ns/1ps
`default_nettype none
module pwd_watchdog_bench;
  localparam integer T = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wire sck, csn, mo, mi, mi_oe, ro_n, ro_oe;
  wire so = mi_oe ? mi : 1'b1;
  wire line_n = ro_oe ? ro_n : 1'b1; // pull-up when released
  integer bad_count = 0;
  integer cmp_count = 0;
  integer seed = 32'he0c5d56a;
  integer i;
  logic [31:0] r;
  logic [7:0] rd;
  logic [6:0] v;
  pwd_watchdog #(.TICK_CYC(T), .PULSE_CYC(8)) uut (.clk_i(clk_i),
    .rst_i(rst_i), .spi_sclk_i(sck), .spi_cs_n_i(csn), .spi_mosi_i(mo),
    .spi_miso_o(mi), .spi_miso_oe_o(mi_oe), .mcu_reset_out_n_o(ro_n),
    .mcu_reset_out_n_oe_o(ro_oe));
  pwd_host_model host (.clk_i(clk_i), .sclk_o(sck), .cs_n_o(csn),
    .mosi_o(mo), .miso_i(so));
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // expectation and checking helpers
  // ----------------------------------------
  function automatic integer ticks(input logic [6:0] c);
    integer m, b;
    begin
      m = c[6] ? 100 : c[5] ? 10 : c[4] ? 1 : 100;
      b = (c[3:0] == 4'h0) ? 1 : (c[3:0] > 4'ha) ? 10 : c[3:0];
      ticks = m * b;
    end
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a, d}, rd);
  endtask
  task rdr(input logic [6:0] a);
    host.xfer({1'b0, a, 8'h00}, rd);
  endtask
  // pulse time rounded to ticks, so filter latency does not matter
  task wait_pulse(input integer n);
    integer c;
    begin
      c = 0;
      while (line_n === 1'b1 && c < 30000) begin
        @(posedge clk_i);
        c = c + 1;
      end
      if (c >= 30000) begin
        bad_count = bad_count + 1;
        report_and_stop;
      end else begin
        check((c + T / 2) / T, n);
        repeat (20) @(posedge clk_i);
      end
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdr(7'h0a);
    check({30'h0, rd[7], rd[6:0] > 7'd119}, 32'h3);
    rdr(7'h0c);
    check({24'h0, rd}, 32'h0);
    rdr(7'h33);
    check({24'h0, rd}, 32'h0);
    // first pass has every multiplier bit set, the rest are random
    for (i = 0; i < 7; i = i + 1) begin
      r = $random(seed);
      if (r[5:4] == 2'b00) r[4] = 1'b1;
      v = (i == 0) ? 7'h71 : {1'b0, r[5:0]};
      wr(7'h0a, {1'b1, v});
      wr(7'h0c, 8'h80);
      wait_pulse(ticks(v));
      rdr(7'h0a);
      check({30'h0, rd[7], rd[6:0] > 7'd119}, 32'h3);
    end
    wr(7'h0a, 8'ha5);
    wr(7'h0c, 8'h23);
    rdr(7'h0c);
    check({24'h0, rd}, 32'h23);
    wr(7'h0c, 8'ha9);
    rdr(7'h0c);
    check({24'h0, rd}, 32'h0);
    // the read frame above costs 17 ticks of the temporary interval
    wait_pulse(ticks(7'h29) - 17);
    // the pulse restored defaults, so set the config up again
    wr(7'h0a, 8'ha5);
    wr(7'h0c, 8'h80);
    wait_pulse(50);
    // a refresh now must load the restored 10 s default
    wr(7'h0c, 8'h80);
    wait_pulse(1000);
    wr(7'h0a, 8'h15);
    wr(7'h0c, 8'h80);
    repeat (400) @(posedge clk_i);
    check({31'h0, line_n}, 32'h1);
    rdr(7'h0a);
    check({31'h0, rd[7]}, 32'h0);
    check({24'h0, rd}, 32'h7f);
    report_and_stop;
  end
endmodule
`default_nettype wire
